// ===== hw/fpp_mac.sv
`timescale 1ns/1ps
module fpp_mac
  import fpp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic en,
  input wire logic [23:0] coef,
  input wire logic [23:0] smp,
  output logic [55:0] acc
);

  logic signed [47:0] prod;

  assign prod = $signed(smp) * $signed(coef);

  // ----------------------------------------------------------------
  // accumulate
  // ----------------------------------------------------------------
  // product Q3.45 aligned to 48 fraction bits; sum may wrap inside the
  // 8 integer bits only if the coefficient set gains over +42 dB
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= 56'h00000000000000;
    end else if (clr) begin
      acc <= 56'h00000000000000;
    end else if (en) begin
      acc <= acc + {{5{prod[47]}}, prod, 3'h0};
    end
  end

endmodule : fpp_mac

// ===== hw/fpp_path.sv
`timescale 1ns/1ps
// Operation
// R1 - output is sum of h[n] times input delayed n samples, n below length
// R2 - direct form: each stored past sample times its coefficient, accumulated
// R3 - host supplies coefficients above -1 and at most +1
// R4 - coefficient set longer than capacity is refused whole
// R5 - accumulator is 56 bits, 8 integer and 48 fraction
// R6 - coefficients are stored with 24 bit resolution
// R7 - left, right, sum, channels 1,2,3,5,6,7 hold up to 1023 coefficients
// R8 - diff and channels 4,8,9,10 hold at most 511 coefficients
// R9 - input delays up to 8191 samples, diff only 4095
// R10 - output channel delays from zero up to 4095 samples
// R11 - empty filter outputs zero, blocking the signal
// R12 - single coefficient one passes input unchanged
// R13 - defaults: zero delay, unity gains, positive polarity
// R14 - defaults: every filter starts empty and blocks
// R15 - default routing: left to odd channels, right to even channels
// R16 - applying defaults mutes output until explicitly unmuted
// R17 - accumulator result saturates when reduced to sample width
// R18 - selectable polarity inversion and gain from -24 to +12 dB
module fpp_path
  import fpp_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic [3:0] PATH_ID,
  input wire logic SAMPLE_EN,
  input wire logic [23:0] IN_LEFT,
  input wire logic [23:0] IN_RIGHT,
  input wire logic SETUP_WR,
  input wire fpp_setup_t SETUP,
  input wire logic DEFAULT_CFG,
  input wire logic UNMUTE,
  input wire fpp_load_t COEF_LOAD,
  input wire logic COEF_VALID,
  input wire logic [23:0] COEF_DATA,
  output logic [23:0] SAMPLE_OUT,
  output logic OUT_VALID,
  output logic COEF_DONE,
  output logic COEF_REFUSED,
  output logic [10:0] TAPS_LOADED,
  output logic MUTED,
  output logic BUSY
);

  fpp_state_t state_r;
  fpp_setup_t setup_r;
  logic [10:0] load_len_r;
  logic [10:0] load_idx_r;
  logic loading_r;
  logic [12:0] dwp_r;
  logic [9:0] hwp_r;
  logic [10:0] tap_r;
  logic [10:0] n_r;
  logic [23:0] fir_r;
  logic [23:0] coef_mem [0:1023];
  logic [23:0] hist_mem [0:1023];
  logic [23:0] dly_mem [0:8191];
  logic [55:0] acc;
  logic [23:0] dly_rd;
  logic [9:0] hist_idx;
  logic [23:0] gained;
  logic [23:0] polar;
  logic signed [47:0] gprod;
  logic mac_clr;
  logic mac_en;

  // ----------------------------------------------------------------
  // configuration
  // ----------------------------------------------------------------
  // delay is clamped rather than refused so a stray large value stays bounded
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      // R13 default setup
      setup_r <= '{delay: FPP_DLY_RST, gain: FPP_GAIN_UNITY, invert: 1'b0, route: 1'b0};
    end else if (DEFAULT_CFG) begin
      // R15 default route
      setup_r <= '{delay: FPP_DLY_RST, gain: FPP_GAIN_UNITY, invert: 1'b0,
                   route: fpp_default_route(PATH_ID)};
    end else if (SETUP_WR) begin
      setup_r.gain <= SETUP.gain;
      setup_r.invert <= SETUP.invert;
      setup_r.route <= SETUP.route;
      // R9 R10 delay limit
      if (SETUP.delay > fpp_delay_max(PATH_ID)) begin
        setup_r.delay <= fpp_delay_max(PATH_ID);
      end else begin
        setup_r.delay <= SETUP.delay;
      end
    end
  end

  // R16 mute on defaults; a new default wins over a same-cycle unmute
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      MUTED <= 1'b1;
    end else if (DEFAULT_CFG) begin
      MUTED <= 1'b1;
    end else if (UNMUTE) begin
      MUTED <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // coefficient loading
  // ----------------------------------------------------------------
  // the active length drops to zero while a set streams in, so a convolution
  // that starts mid-load never uses a half loaded set
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      // R14 empty after reset
      TAPS_LOADED <= FPP_TAPS_RST;
      loading_r <= 1'b0;
      load_len_r <= FPP_TAPS_RST;
      load_idx_r <= FPP_TAPS_RST;
      COEF_DONE <= 1'b0;
      COEF_REFUSED <= 1'b0;
    end else begin
      COEF_DONE <= 1'b0;
      COEF_REFUSED <= 1'b0;
      if (DEFAULT_CFG) begin
        // R14 defaults empty
        TAPS_LOADED <= FPP_TAPS_RST;
        loading_r <= 1'b0;
      end else if (COEF_LOAD.start) begin
        // R4 R7 R8 capacity check
        if (COEF_LOAD.len > fpp_capacity(PATH_ID)) begin
          COEF_REFUSED <= 1'b1;
        end else if (COEF_LOAD.len == FPP_TAPS_RST) begin
          // R11 empty set blocks
          TAPS_LOADED <= FPP_TAPS_RST;
          loading_r <= 1'b0;
          COEF_DONE <= 1'b1;
        end else begin
          TAPS_LOADED <= FPP_TAPS_RST;
          loading_r <= 1'b1;
          load_len_r <= COEF_LOAD.len;
          load_idx_r <= FPP_TAPS_RST;
        end
      end else if (loading_r && COEF_VALID) begin
        load_idx_r <= load_idx_r + 11'h001;
        if (load_idx_r == load_len_r - 11'h001) begin
          loading_r <= 1'b0;
          TAPS_LOADED <= load_len_r;
          COEF_DONE <= 1'b1;
        end
      end
    end
  end

  // R6 24-bit store; R3 range is the host's duty, +1 is 0x400000
  always_ff @(posedge CLK_SYS) begin
    if (loading_r && COEF_VALID && !COEF_LOAD.start && !DEFAULT_CFG) begin
      coef_mem[load_idx_r[9:0]] <= COEF_DATA;
    end
  end

  // ----------------------------------------------------------------
  // sample sequencer
  // ----------------------------------------------------------------
  // one convolution per sample enable; taps cost one cycle each, so the
  // enable period must be at least the loaded length plus four cycles
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= FPP_S_IDLE;
      dwp_r <= FPP_DLY_RST;
      hwp_r <= 10'h000;
      tap_r <= FPP_TAPS_RST;
      n_r <= FPP_TAPS_RST;
    end else begin
      case (state_r)
        FPP_S_IDLE: begin
          if (SAMPLE_EN) begin
            state_r <= FPP_S_DLY;
          end
        end
        FPP_S_DLY: begin
          dwp_r <= dwp_r + 13'h0001;
          hwp_r <= hwp_r + 10'h001;
          tap_r <= FPP_TAPS_RST;
          n_r <= TAPS_LOADED;
          state_r <= (TAPS_LOADED == FPP_TAPS_RST) ? FPP_S_SAT : FPP_S_MAC;
        end
        FPP_S_MAC: begin
          tap_r <= tap_r + 11'h001;
          if (tap_r == n_r - 11'h001) begin
            state_r <= FPP_S_SAT;
          end
        end
        FPP_S_SAT: begin
          state_r <= FPP_S_OUT;
        end
        FPP_S_OUT: begin
          state_r <= FPP_S_IDLE;
        end
        default: begin
          state_r <= FPP_S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sample memories
  // ----------------------------------------------------------------
  // R9 R10 circular delay line; delay zero reads the sample just written
  assign dly_rd = dly_mem[dwp_r - setup_r.delay];

  always_ff @(posedge CLK_SYS) begin
    if (state_r == FPP_S_IDLE && SAMPLE_EN) begin
      dly_mem[dwp_r] <= (setup_r.route == FPP_SRC_RIGHT) ? IN_RIGHT : IN_LEFT;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (state_r == FPP_S_DLY) begin
      hist_mem[hwp_r + 10'h001] <= dly_rd;
    end
  end

  // ----------------------------------------------------------------
  // convolution
  // ----------------------------------------------------------------
  // R1 R2 tap n pairs h[n] with the sample n steps older
  assign hist_idx = hwp_r - tap_r[9:0];
  assign mac_clr = (state_r == FPP_S_DLY);
  assign mac_en = (state_r == FPP_S_MAC);

  // R5 56-bit accumulator
  fpp_mac u_mac (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .clr(mac_clr),
    .en(mac_en),
    .coef(coef_mem[tap_r[9:0]]),
    .smp(hist_mem[hist_idx]),
    .acc(acc)
  );

  // R17 saturate to sample; R11 R12 zero or unity taps fall out exactly
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      fir_r <= 24'h000000;
    end else if (state_r == FPP_S_SAT) begin
      fir_r <= fpp_sat_acc(acc);
    end
  end

  // ----------------------------------------------------------------
  // gain, polarity, mute
  // ----------------------------------------------------------------
  assign gprod = $signed(fir_r) * $signed(setup_r.gain);
  // R18 gain with saturation
  assign gained = fpp_sat_gain(gprod);
  // R18 polarity, full-scale negative maps to positive full scale
  assign polar = !setup_r.invert ? gained :
                 (gained == FPP_SMP_MIN) ? FPP_SMP_MAX : (24'h000000 - gained);

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      SAMPLE_OUT <= 24'h000000;
      OUT_VALID <= 1'b0;
      BUSY <= 1'b0;
    end else begin
      OUT_VALID <= (state_r == FPP_S_OUT);
      BUSY <= (state_r != FPP_S_IDLE) || (state_r == FPP_S_IDLE && SAMPLE_EN);
      if (state_r == FPP_S_OUT) begin
        // R16 muted output
        SAMPLE_OUT <= MUTED ? 24'h000000 : polar;
      end
    end
  end

endmodule : fpp_path

// ===== hw/fpp_pkg.sv
package fpp_pkg;

  // ----------------------------------------------------------------
  // widths and fixed formats
  // ----------------------------------------------------------------
  localparam int FPP_SMP_W = 24;
  localparam int FPP_COEF_W = 24;
  localparam int FPP_ACC_W = 56;
  localparam int FPP_ACC_INT = 8;
  localparam int FPP_ACC_FRAC = 48;
  localparam int FPP_GAIN_W = 24;
  localparam int FPP_TAP_AW = 10;
  localparam int FPP_LEN_W = 11;
  localparam int FPP_DLY_AW = 13;

  // coefficients are Q2.22 so that +1.0 is representable; samples Q1.23
  localparam logic [23:0] FPP_COEF_ONE = 24'h400000;
  // gain is a linear Q4.20 multiplier, unity after reset
  localparam logic [23:0] FPP_GAIN_UNITY = 24'h100000;
  localparam logic [23:0] FPP_SMP_MAX = 24'h7FFFFF;
  localparam logic [23:0] FPP_SMP_MIN = 24'h800000;

  // ----------------------------------------------------------------
  // capacities and reset values
  // ----------------------------------------------------------------
  localparam logic [10:0] FPP_CAP_LONG = 11'h3FF;
  localparam logic [10:0] FPP_CAP_SHORT = 11'h1FF;
  localparam logic [12:0] FPP_DLY_MAX_LONG = 13'h1FFF;
  localparam logic [12:0] FPP_DLY_MAX_SHORT = 13'h0FFF;
  localparam logic [12:0] FPP_DLY_RST = 13'h0000;
  localparam logic [10:0] FPP_TAPS_RST = 11'h000;

  // ----------------------------------------------------------------
  // path identities and routing sources
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    FPP_P_LEFT = 4'h0, FPP_P_RIGHT = 4'h1, FPP_P_SUM = 4'h2, FPP_P_DIFF = 4'h3,
    FPP_P_CH1 = 4'h4, FPP_P_CH2 = 4'h5, FPP_P_CH3 = 4'h6, FPP_P_CH4 = 4'h7,
    FPP_P_CH5 = 4'h8, FPP_P_CH6 = 4'h9, FPP_P_CH7 = 4'hA, FPP_P_CH8 = 4'hB,
    FPP_P_CH9 = 4'hC, FPP_P_CH10 = 4'hD
  } fpp_path_t;

  localparam logic FPP_SRC_LEFT = 1'b0;
  localparam logic FPP_SRC_RIGHT = 1'b1;

  typedef struct packed {
    logic [12:0] delay;
    logic [23:0] gain;
    logic invert;
    logic route;
  } fpp_setup_t;

  typedef struct packed {
    logic start;
    logic [10:0] len;
  } fpp_load_t;

  typedef enum logic [4:0] {
    FPP_S_IDLE = 5'b00001,
    FPP_S_DLY = 5'b00010,
    FPP_S_MAC = 5'b00100,
    FPP_S_SAT = 5'b01000,
    FPP_S_OUT = 5'b10000
  } fpp_state_t;

  // ----------------------------------------------------------------
  // decoding shared by several processes
  // ----------------------------------------------------------------
  function automatic logic [10:0] fpp_capacity(input logic [3:0] id);
    case (id)
      FPP_P_DIFF, FPP_P_CH4, FPP_P_CH8, FPP_P_CH9, FPP_P_CH10: fpp_capacity = FPP_CAP_SHORT;
      default: fpp_capacity = FPP_CAP_LONG;
    endcase
  endfunction : fpp_capacity

  function automatic logic [12:0] fpp_delay_max(input logic [3:0] id);
    if (id == FPP_P_DIFF || id > FPP_P_DIFF) begin
      fpp_delay_max = FPP_DLY_MAX_SHORT;
    end else begin
      fpp_delay_max = FPP_DLY_MAX_LONG;
    end
  endfunction : fpp_delay_max

  // odd channels and left/sum/diff take left, even channels and right take right
  function automatic logic fpp_default_route(input logic [3:0] id);
    if (id == FPP_P_RIGHT) begin
      fpp_default_route = FPP_SRC_RIGHT;
    end else if (id > FPP_P_DIFF) begin
      // ch1 has an even identity, so an even id means an odd channel
      fpp_default_route = id[0];
    end else begin
      fpp_default_route = FPP_SRC_LEFT;
    end
  endfunction : fpp_default_route

  function automatic logic [23:0] fpp_sat_acc(input logic [55:0] acc);
    if (acc[55:48] == 8'h00 || acc[55:48] == 8'hFF) begin
      fpp_sat_acc = acc[48:25];
    end else begin
      fpp_sat_acc = acc[55] ? FPP_SMP_MIN : FPP_SMP_MAX;
    end
  endfunction : fpp_sat_acc

  function automatic logic [23:0] fpp_sat_gain(input logic [47:0] p);
    if (p[47:43] == 5'h00 || p[47:43] == 5'h1F) begin
      fpp_sat_gain = p[43:20];
    end else begin
      fpp_sat_gain = p[47] ? FPP_SMP_MIN : FPP_SMP_MAX;
    end
  endfunction : fpp_sat_gain

endpackage : fpp_pkg

// ===== tb/fpp_host.sv
`timescale 1ns/1ps
module fpp_host
  import fpp_pkg::*;
(
  input wire logic clk,
  output fpp_load_t load,
  output logic valid,
  output logic [23:0] data
);
  // ----------------------------------------------------------------
  // coefficient loader
  // ----------------------------------------------------------------
  initial begin
    load = '0;
    valid = 1'b0;
    data = 24'h000000;
  end
  task automatic send(input int len, input logic [23:0] c);
    logic [23:0] w;
    w = c;
    if ($signed(w) <= -24'sh400000 || $signed(w) > 24'sh400000) w = 24'h000000;
    @(negedge clk);
    load = '{start: 1'b1, len: len[10:0]};
    @(negedge clk);
    load.start = 1'b0;
    for (int k = 0; k < len; k++) begin
      data = w;
      valid = 1'b1;
      @(negedge clk);
    end
    valid = 1'b0;
    // released data shows the inverse, so a stale word is never read as good
    data = ~w;
  endtask : send
endmodule : fpp_host

// ===== tb/fpp_path_checker.sv
`timescale 1ns/1ps
module fpp_path_checker
  import fpp_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic [3:0] PATH_ID,
  input wire logic SAMPLE_EN,
  input wire logic DEFAULT_CFG,
  input wire logic UNMUTE,
  input wire fpp_load_t COEF_LOAD,
  input wire logic [23:0] SAMPLE_OUT,
  input wire logic OUT_VALID,
  input wire logic COEF_DONE,
  input wire logic COEF_REFUSED,
  input wire logic [10:0] TAPS_LOADED,
  input wire logic MUTED,
  input wire logic BUSY
);
  // ----------------------------------------------------------------
  // capacity seen from the path identity
  // ----------------------------------------------------------------
  logic [10:0] cap;
  assign cap = (PATH_ID inside {4'h3, 4'h7, 4'hB, 4'hC, 4'hD}) ? 11'h1FF : 11'h3FF;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  out_pulse_a: assert property (OUT_VALID |=> !OUT_VALID)
    else $error("output valid longer than one cycle");
  busy_take_a: assert property (SAMPLE_EN && !BUSY |=> BUSY)
    else $error("sample not taken");
  // empty filter answers at the fourth edge with zero
  empty_out_a: assert property (SAMPLE_EN && !BUSY && TAPS_LOADED == 11'h000 && !DEFAULT_CFG
    |=> BUSY ##3 (OUT_VALID && SAMPLE_OUT == 24'h000000))
    else $error("empty filter did not block");
  refuse_long_a: assert property (COEF_LOAD.start && !DEFAULT_CFG && COEF_LOAD.len > cap
    |=> COEF_REFUSED && $stable(TAPS_LOADED))
    else $error("oversized set not refused whole");
  accept_fit_a: assert property (COEF_LOAD.start && !DEFAULT_CFG && COEF_LOAD.len <= cap
    |=> !COEF_REFUSED)
    else $error("fitting set refused");
  taps_cap_a: assert property (TAPS_LOADED <= cap)
    else $error("active length above capacity");
  done_excl_a: assert property (COEF_REFUSED |-> !COEF_DONE)
    else $error("done and refused together");
  default_mute_a: assert property (DEFAULT_CFG |=> MUTED && TAPS_LOADED == 11'h000)
    else $error("defaults did not empty and mute");
  unmute_a: assert property (UNMUTE && !DEFAULT_CFG |=> !MUTED)
    else $error("unmute ignored");
  muted_out_a: assert property (OUT_VALID && MUTED && $past(MUTED)
    |-> SAMPLE_OUT == 24'h000000)
    else $error("muted output not zero");
  cover property (COEF_REFUSED);
  cover property (COEF_DONE && TAPS_LOADED == 11'h3FF);
  cover property (OUT_VALID && !MUTED && SAMPLE_OUT != 24'h000000);
endmodule : fpp_path_checker

bind fpp_path fpp_path_checker u_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .PATH_ID(PATH_ID),
  .SAMPLE_EN(SAMPLE_EN), .DEFAULT_CFG(DEFAULT_CFG), .UNMUTE(UNMUTE), .COEF_LOAD(COEF_LOAD),
  .SAMPLE_OUT(SAMPLE_OUT), .OUT_VALID(OUT_VALID), .COEF_DONE(COEF_DONE),
  .COEF_REFUSED(COEF_REFUSED), .TAPS_LOADED(TAPS_LOADED), .MUTED(MUTED), .BUSY(BUSY));

// ===== tb/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb;
  import fpp_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic sample_en = 1'b0;
  logic setup_wr = 1'b0;
  logic default_cfg = 1'b0;
  logic unmute = 1'b0;
  logic [3:0] path_id = 4'h4;
  logic [23:0] in_left = 24'h000000;
  logic [23:0] in_right = 24'h000000;
  fpp_setup_t setup = '0;
  fpp_load_t coef_load;
  logic coef_valid;
  logic [23:0] coef_data;
  logic [23:0] sample_out;
  logic out_valid, coef_done, coef_refused, muted, busy, done_seen, ref_seen;
  logic [10:0] taps_loaded;
  int failures = 0;
  int num_checks = 0;
  initial forever #5 clk_sys = ~clk_sys;
  fpp_host host (.clk(clk_sys), .load(coef_load), .valid(coef_valid), .data(coef_data));
  fpp_path dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .PATH_ID(path_id), .SAMPLE_EN(sample_en),
    .IN_LEFT(in_left), .IN_RIGHT(in_right), .SETUP_WR(setup_wr), .SETUP(setup),
    .DEFAULT_CFG(default_cfg), .UNMUTE(unmute), .COEF_LOAD(coef_load),
    .COEF_VALID(coef_valid), .COEF_DATA(coef_data), .SAMPLE_OUT(sample_out),
    .OUT_VALID(out_valid), .COEF_DONE(coef_done), .COEF_REFUSED(coef_refused),
    .TAPS_LOADED(taps_loaded), .MUTED(muted), .BUSY(busy));
  always @(posedge clk_sys) begin
    if (coef_done) done_seen = 1'b1;
    if (coef_refused) ref_seen = 1'b1;
  end
  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic smp(input logic [23:0] x, output logic [23:0] y);
    int n;
    @(negedge clk_sys);
    in_left = x;
    in_right = ~x;
    sample_en = 1'b1;
    @(negedge clk_sys);
    sample_en = 1'b0;
    `CHK(busy, 1'b1)
    n = 0;
    while (out_valid !== 1'b1 && n < 2000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 2000) failures++;
    y = sample_out;
  endtask : smp
  task automatic load(input int len, input logic [23:0] c, input logic exp_ref);
    done_seen = 1'b0;
    ref_seen = 1'b0;
    host.send(len, c);
    repeat (2) @(negedge clk_sys);
    `CHK(ref_seen, exp_ref)
    `CHK(done_seen, ~exp_ref)
  endtask : load
  task automatic cfg(input logic [12:0] d, input logic [23:0] g, input logic inv);
    @(negedge clk_sys);
    setup = '{delay: d, gain: g, invert: inv, route: FPP_SRC_LEFT};
    setup_wr = 1'b1;
    @(negedge clk_sys);
    setup_wr = 1'b0;
  endtask : cfg
  task automatic strobe(input logic d, input logic u);
    @(negedge clk_sys);
    default_cfg = d;
    unmute = u;
    @(negedge clk_sys);
    default_cfg = 1'b0;
    unmute = 1'b0;
  endtask : strobe
  task give_verdict;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict
  initial begin
    #500000;
    failures++;
    give_verdict;
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    logic [23:0] y;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    `CHK(muted, 1'b1)
    strobe(1'b1, 1'b0);
    strobe(1'b0, 1'b1);
    `CHK(taps_loaded, 11'h000)
    `CHK(muted, 1'b0)
    smp(24'h345678, y);
    `CHK(y, 24'h000000)
    load(1, FPP_COEF_ONE, 1'b0);
    smp(24'h123456, y);
    `CHK(y, 24'h123456)
    load(2, FPP_COEF_ONE, 1'b0);
    smp(24'h300000, y);
    `CHK(y, 24'h423456)
    smp(24'h7FFFFF, y);
    `CHK(y, 24'h7FFFFF)
    // half gain, inverted: saturated sum halves and then negates
    cfg(13'h0000, 24'h080000, 1'b1);
    smp(24'h200000, y);
    `CHK(y, 24'hC00001)
    load(1, FPP_COEF_ONE, 1'b0);
    cfg(13'h0002, FPP_GAIN_UNITY, 1'b0);
    smp(24'h111111, y);
    smp(24'h222222, y);
    smp(24'h333333, y);
    `CHK(y, 24'h111111)
    strobe(1'b1, 1'b0);
    `CHK(taps_loaded, 11'h000)
    load(1, FPP_COEF_ONE, 1'b0);
    smp(24'h654321, y);
    `CHK(y, 24'h000000)
    strobe(1'b0, 1'b1);
    smp(24'h0ABCDE, y);
    `CHK(y, 24'h0ABCDE)
    load(1023, 24'h000000, 1'b0);
    `CHK(taps_loaded, 11'h3FF)
    load(1024, 24'h000000, 1'b1);
    `CHK(taps_loaded, 11'h3FF)
    load(0, 24'h000000, 1'b0);
    `CHK(taps_loaded, 11'h000)
    // ch4: short capacity, default route takes the right input
    path_id = 4'h7;
    load(512, 24'h000000, 1'b1);
    `CHK(taps_loaded, 11'h000)
    strobe(1'b1, 1'b1);
    `CHK(muted, 1'b1)
    strobe(1'b0, 1'b1);
    load(1, FPP_COEF_ONE, 1'b0);
    smp(24'h0F0F0F, y);
    `CHK(y, 24'hF0F0F0)
    load(511, 24'h000000, 1'b0);
    `CHK(taps_loaded, 11'h1FF)
    give_verdict;
  end
endmodule : tb
